// File: shared/tcasm_map.svh
/*
 * Register offsets, field positions, reset values and timing figures of
 * the customer-installation alarm monitor.
 * Assumes it is included by bare name once per compile unit user.
 */
`ifndef TCASM_MAP_SVH
`define TCASM_MAP_SVH

// ============================================================
// Register offsets
`define TCASM_ADDR_W          4
`define TCASM_OFF_STATUS      4'h0
`define TCASM_OFF_CONTROL     4'h1
`define TCASM_OFF_IRQ_MASK    4'h2

// ============================================================
// Status register fields
`define TCASM_BIT_AIS_STATE   5
`define TCASM_BIT_RAI_STATE   4
`define TCASM_BIT_AIS_CHANGE  1
`define TCASM_BIT_RAI_CHANGE  0

// ============================================================
// Control register fields and reset values
`define TCASM_BIT_AIS_DET_EN  0
`define TCASM_BIT_RAI_DET_EN  1
`define TCASM_BIT_ESF_MODE    2
`define TCASM_CONTROL_RST     8'h00
`define TCASM_IRQ_MASK_RST    8'h00

// ============================================================
// Line patterns, first received bit in bit 0
`define TCASM_AIS_SIGNATURE   16'hFF7C
`define TCASM_RAI_MESSAGE     16'hFF00
`define TCASM_RAI_SIGNATURE   16'hFF3E
`define TCASM_AIS_SPACING     386
`define TCASM_AIS_SET_PERIODS 4

// ============================================================
// Timing
`define TCASM_CLK_KHZ         100000
`define TCASM_RAI_PERIOD_MS   1080
`define TCASM_RAI_MESSAGE_MS  990
`define TCASM_RAI_SIG_MS      90

`endif

// File: shared/tcasm_pkg.sv
/*
 * Types of the customer-installation alarm monitor.
 * Assumes tcasm_map.svh is on the include path.
 */
`include "tcasm_map.svh"

package tcasm_pkg;

    // ============================================================
    // Register port request from software.
    typedef struct packed {
        logic [`TCASM_ADDR_W-1:0] addr;
        logic [7:0]               wdata;
        logic                     wr;
        logic                     rd;
    } tcasm_bus_s;

    // ============================================================
    // Receive stream from the framer: payload bit and data-link bit.
    typedef struct packed {
        logic line_bit;
        logic line_en;
        logic dl_bit;
        logic dl_en;
    } tcasm_rx_s;

    // AIS-CI signature tracker states.
    typedef enum logic [0:0] {
        TCASM_AIS_HUNT  = 1'b0,
        TCASM_AIS_TRACK = 1'b1
    } tcasm_ais_e;

endpackage

// File: rtl/tcasm_monitor.sv
/*
 * Customer-installation alarm monitor for the receive T1 framer. It
 * hunts AIS-CI in the payload stream and RAI-CI in the ESF data link,
 * keeps state bits, change flags and one interrupt.
 * Assumes line and data-link strobes are synchronous one-cycle pulses
 * from the framer on sys_clk, with bits in arrival order.
 */
// Operation
// - Status bit 5 is read-only, resets to 0 and shows AIS-CI detection.
// - AIS-CI is all ones with signature 01111100 11111111 every 386 bits.
// - Status bit 4 is read-only, resets to 0 and shows RAI-CI declared.
// - RAI-CI is detected and reported only in ESF framing mode.
// - RAI-CI repeats every 1.08 s: 0.99 s of message, 90 ms of signature.
// - Message is 00000000 then ones, signature 00111110 then ones.
// - The AIS-CI state bit updates only while its detection is enabled.
// - The RAI-CI state bit updates only while its detection is enabled; leaving ESF mode clears it regardless.
// - Each condition change, set or clear, latches a flag cleared by read.
`timescale 1ns/1ns
`include "tcasm_map.svh"

module tcasm_monitor #(
    parameter int AIS_SPACING     = `TCASM_AIS_SPACING,
    parameter int AIS_SET_PERIODS = `TCASM_AIS_SET_PERIODS,
    parameter int RAI_PERIOD_CYC  =
        `TCASM_RAI_PERIOD_MS * (`TCASM_CLK_KHZ)
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire tcasm_pkg::tcasm_bus_s bus,
    output logic [7:0]                 rd_data,
    // Receive stream
    input  wire tcasm_pkg::tcasm_rx_s  rx,
    // Alarm state and interrupt
    output logic                       rx_ci_alarm_signal_state,
    output logic                       rx_ci_remote_alarm_state,
    output logic                       irq
);
    import tcasm_pkg::*;

    // ============================================================
    // Elaboration checks
    generate
        if (AIS_SPACING < 17 || AIS_SPACING > 511) begin : g_bad_spacing
            $error("AIS spacing outside 17..511 bits");
        end
        if (AIS_SET_PERIODS < 1 || AIS_SET_PERIODS > 15) begin : g_bad_set
            $error("AIS set periods outside 1..15");
        end
        if (RAI_PERIOD_CYC < 2) begin : g_bad_period
            $error("RAI period shorter than two cycles");
        end
        if (RAI_PERIOD_CYC > 1000000000) begin : g_long_period
            $error("RAI period too long for the loss timer");
        end
    endgenerate

    // A loss timeout of one and a half periods tolerates a late signature.
    localparam int RAI_LOSS_CYC = RAI_PERIOD_CYC + RAI_PERIOD_CYC / 2;
    localparam int TMR_W        = $clog2(RAI_LOSS_CYC + 1);

    // True when a 16-bit window holds the given pattern.
    function automatic logic pat_hit(input logic [15:0] win,
                                     input logic [15:0] pat);
        pat_hit = (win == pat);
    endfunction

    // ============================================================
    // Software registers
    logic [7:0] control;
    logic [7:0] irq_mask;
    logic [1:0] change;
    logic       wr_status;
    logic       rd_status;
    logic       ais_en;
    logic       rai_en;
    logic       esf_mode;

    assign wr_status = bus.wr && bus.addr == `TCASM_OFF_STATUS;
    assign rd_status = bus.rd && bus.addr == `TCASM_OFF_STATUS;
    assign ais_en    = control[`TCASM_BIT_AIS_DET_EN];
    assign rai_en    = control[`TCASM_BIT_RAI_DET_EN];
    assign esf_mode  = control[`TCASM_BIT_ESF_MODE];

    // Control and mask registers; only defined bits are writable.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            control  <= `TCASM_CONTROL_RST;
            irq_mask <= `TCASM_IRQ_MASK_RST;
        end else if (bus.wr) begin
            if (bus.addr == `TCASM_OFF_CONTROL) begin
                control <= bus.wdata & 8'h07;
            end
            if (bus.addr == `TCASM_OFF_IRQ_MASK) begin
                irq_mask <= bus.wdata & 8'h03;
            end
        end
    end

    // ============================================================
    // AIS-CI: signature spacing tracker on the payload stream
    logic [15:0] line_win;
    logic [8:0]  ais_gap;
    logic [3:0]  ais_good;
    tcasm_ais_e  ais_fsm;
    logic        ais_hit;
    logic        ais_seen;

    // Newest bit enters at the top, so the first bit ends in bit 0.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_win <= 16'h0000;
        end else if (rx.line_en) begin
            line_win <= {rx.line_bit, line_win[15:1]};
        end
    end

    assign ais_hit = rx.line_en &&
        pat_hit({rx.line_bit, line_win[15:1]}, `TCASM_AIS_SIGNATURE);

    // Signatures must recur exactly one spacing apart; a missing or early
    // one restarts the count, so ordinary all-ones AIS never qualifies.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ais_fsm  <= TCASM_AIS_HUNT;
            ais_gap  <= 9'h000;
            ais_good <= 4'h0;
        end else if (rx.line_en) begin
            unique case (ais_fsm)
                TCASM_AIS_HUNT: begin
                    ais_good <= 4'h0;
                    if (ais_hit) begin
                        ais_fsm <= TCASM_AIS_TRACK;
                        ais_gap <= 9'h001;
                    end
                end
                TCASM_AIS_TRACK: begin
                    if (ais_hit && ais_gap == 9'(AIS_SPACING)) begin
                        ais_gap <= 9'h001;
                        if (ais_good != 4'(AIS_SET_PERIODS)) begin
                            ais_good <= ais_good + 4'h1;
                        end
                    end else if (ais_hit || ais_gap >= 9'(AIS_SPACING)) begin
                        ais_fsm  <= TCASM_AIS_HUNT;
                        ais_gap  <= 9'h000;
                        ais_good <= 4'h0;
                    end else begin
                        ais_gap <= ais_gap + 9'h001;
                    end
                end
            endcase
        end
    end

    assign ais_seen = ais_good == 4'(AIS_SET_PERIODS);

    // ============================================================
    // RAI-CI: message then signature on the ESF data link
    logic [15:0]      dl_win;
    logic [3:0]       dl_phase;
    logic             rai_msg_hit;
    logic             rai_sig_hit;
    logic             msg_armed;
    logic             rai_seen;
    logic [TMR_W-1:0] rai_tmr;

    // Codewords are 16 bits long. The phase counts bits since the last
    // codeword, so a signature counts only on the word boundary after a
    // message word; a stray match in mid-word cannot declare the alarm.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dl_win   <= 16'h0000;
            dl_phase <= 4'h0;
        end else if (rx.dl_en) begin
            dl_win   <= {rx.dl_bit, dl_win[15:1]};
            dl_phase <= (rai_msg_hit || rai_sig_hit) ? 4'h0 :
                        dl_phase + 4'h1;
        end
    end

    assign rai_msg_hit = rx.dl_en && esf_mode &&
        pat_hit({rx.dl_bit, dl_win[15:1]}, `TCASM_RAI_MESSAGE);
    assign rai_sig_hit = rx.dl_en && esf_mode &&
        pat_hit({rx.dl_bit, dl_win[15:1]}, `TCASM_RAI_SIGNATURE);

    // Declared when a signature follows message words; cleared when no
    // signature arrives within the loss time or ESF framing is left.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msg_armed <= 1'b0;
            rai_seen  <= 1'b0;
            rai_tmr   <= '0;
        end else if (!esf_mode) begin
            msg_armed <= 1'b0;
            rai_seen  <= 1'b0;
            rai_tmr   <= '0;
        end else begin
            if (rai_msg_hit) begin
                msg_armed <= 1'b1;
            end
            if (rai_sig_hit) begin
                // Only a signature one word after a message word counts.
                rai_seen  <= (msg_armed && dl_phase == 4'hF) ||
                             rai_seen;
                msg_armed <= 1'b0;
                rai_tmr   <= '0;
            end else if (rai_tmr == TMR_W'(RAI_LOSS_CYC)) begin
                rai_seen  <= 1'b0;
                msg_armed <= 1'b0;
            end else begin
                rai_tmr <= rai_tmr + TMR_W'(1);
            end
        end
    end

    // ============================================================
    // State bits, held while the matching detection is disabled; the RAI-CI bit clears when ESF is left.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_ci_alarm_signal_state <= 1'b0;
            rx_ci_remote_alarm_state <= 1'b0;
        end else begin
            if (ais_en) begin
                rx_ci_alarm_signal_state <= ais_seen;
            end
            if (!esf_mode) begin
                rx_ci_remote_alarm_state <= 1'b0;
            end else if (rai_en) begin
                rx_ci_remote_alarm_state <= rai_seen;
            end
        end
    end

    // ============================================================
    // Change flags: set on either edge of a state bit, cleared by a
    // status read or a written one; a new change wins over the clear.
    logic [1:0] next_change;
    logic [1:0] change_evt;
    logic       ais_next;
    logic       rai_next;

    always_comb begin
        ais_next = ais_en ? ais_seen : rx_ci_alarm_signal_state;
        rai_next = !esf_mode ? 1'b0 :
                   rai_en ? rai_seen : rx_ci_remote_alarm_state;
        change_evt = {ais_next != rx_ci_alarm_signal_state,
                      rai_next != rx_ci_remote_alarm_state};
        next_change = change;
        if (rd_status) begin
            next_change = 2'b00;
        end else if (wr_status) begin
            next_change = change & ~bus.wdata[1:0];
        end
        next_change = next_change | change_evt;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            change <= 2'b00;
        end else begin
            change <= next_change;
        end
    end

    // Level interrupt, registered from the next flag values so it moves with them.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_change & irq_mask[1:0]);
        end
    end

    // ============================================================
    // Read data, valid only in the cycle after the read strobe.
    logic [7:0] status_view;

    always_comb begin
        status_view = 8'h00;
        status_view[`TCASM_BIT_AIS_STATE]  = rx_ci_alarm_signal_state;
        status_view[`TCASM_BIT_RAI_STATE]  = rx_ci_remote_alarm_state;
        status_view[`TCASM_BIT_AIS_CHANGE] = change[1];
        status_view[`TCASM_BIT_RAI_CHANGE] = change[0];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `TCASM_OFF_STATUS:   rd_data <= status_view;
                `TCASM_OFF_CONTROL:  rd_data <= control;
                `TCASM_OFF_IRQ_MASK: rd_data <= irq_mask;
                default:             rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule

// File: dv/tcasm_line_model.sv
/* Framer-side line model: payload and data-link strobes with the AIS-CI
 * and RAI-CI patterns. Assumes one clock shared with the monitor. */
`timescale 1ns/1ns
module tcasm_line_model #(
    parameter int SPACING = 386
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    // Pattern selection
    input  wire logic            ais_on,
    input  wire logic            rai_on,
    input  wire logic            slow,
    // Stream to the monitor
    output tcasm_pkg::tcasm_rx_s rx
);
    import tcasm_pkg::*;
    localparam logic [15:0] AIS = 16'hFF7C;
    localparam logic [15:0] MSG = 16'hFF00;
    localparam logic [15:0] SIG = 16'hFF3E;
    int   pos;
    int   dpos;
    logic tog;
    logic go;
    assign go = !slow || tog;
    // ============================================================
    // Bit source
    // Idle bits flip every cycle so a stale bit never passes for data.
    // Eleven message words then one signature word keep the 11:1 ratio.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx   <= '0;
            pos  <= 0;
            dpos <= 0;
            tog  <= 1'b0;
        end else begin
            tog         <= ~tog;
            rx.line_en  <= go;
            rx.dl_en    <= go;
            rx.line_bit <= ~rx.line_bit;
            rx.dl_bit   <= ~rx.dl_bit;
            if (go) begin
                pos  <= (pos == SPACING - 1) ? 0 : pos + 1;
                dpos <= (dpos == 191) ? 0 : dpos + 1;
                if (ais_on)
                    rx.line_bit <= (pos < 16) ? AIS[pos[3:0]] : 1'b1;
                if (rai_on)
                    rx.dl_bit <= (dpos < 176) ? MSG[dpos[3:0]] :
                                 SIG[dpos[3:0]];
            end
        end
    end
endmodule

// File: dv/tcasm_chk.sv
/* Port checker of the alarm monitor.
 * Assumes it is bound to tcasm_monitor from the bench top. */
`timescale 1ns/1ns
module tcasm_chk (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  sys_rst,
    // Register port
    input wire tcasm_pkg::tcasm_bus_s bus,
    input wire logic [7:0]            rd_data,
    // Alarm state and interrupt
    input wire logic                  rx_ci_alarm_signal_state,
    input wire logic                  rx_ci_remote_alarm_state,
    input wire logic                  irq
);
    import tcasm_pkg::*;
    logic [2:0] ctl;
    logic [1:0] msk;
    wire  ais = rx_ci_alarm_signal_state;
    wire  rai = rx_ci_remote_alarm_state;
    // ============================================================
    // Shadow of the control and mask writes, kept to their live bits.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl <= 3'h0;
            msk <= 2'h0;
        end else if (bus.wr && bus.addr == 4'h1) begin
            ctl <= bus.wdata[2:0];
        end else if (bus.wr && bus.addr == 4'h2) begin
            msk <= bus.wdata[1:0];
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence st_rd;
        $past(bus.rd) && $past(bus.addr) == 4'h0;
    endsequence
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !ais && !rai && !irq) else $error("outputs not clear after reset");
    a_unmapped_zero: assert property ($past(bus.rd) &&
        $past(bus.addr) > 4'h2 |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_status_reserved: assert property (st_rd |->
        (rd_data & 8'hCC) == 8'h00) else $error("reserved status bits set");
    a_ais_readback: assert property (st_rd |->
        rd_data[5] == $past(ais)) else $error("status bit 5 differs");
    a_rai_readback: assert property (st_rd |->
        rd_data[4] == $past(rai)) else $error("status bit 4 differs");
    a_rai_needs_esf: assert property ((!ctl[2])[*2] |-> !rai)
        else $error("remote alarm outside ESF");
    a_ais_hold_dis: assert property (!ctl[0] && !$past(ctl[0]) |->
        $stable(ais)) else $error("alarm state moved while disabled");
    a_rai_hold_dis: assert property (!ctl[1] && !$past(ctl[1]) && ctl[2]
        && $past(ctl[2]) |-> $stable(rai)) else $error("remote state moved");
    // The interrupt rises with the state bit, under the mask of that edge.
    a_change_irq: assert property (($changed(ais) && $past(msk[1])) ||
        ($changed(rai) && $past(msk[0])) |-> irq)
        else $error("no irq on change");
    a_irq_masked: assert property ((msk == 2'h0)[*2] |-> !irq)
        else $error("irq while masked");
    c_ais_up: cover property ($rose(ais));
    c_rai_up: cover property ($rose(rai));
    c_irq_up: cover property ($rose(irq));
    c_esf_drop: cover property ($fell(rai) && !ctl[2]);
endmodule

// File: dv/tb.sv
/* Bench top of the alarm monitor: register, AIS-CI and RAI-CI scenarios.
 * Assumes the line model and the checker are compiled before it. */
`timescale 1ns/1ns
module tb;
    import tcasm_pkg::*;
    logic       sys_clk, sys_rst, ais_s, rai_s, irq;
    logic       ais_on, rai_on, slow, rd_q;
    tcasm_bus_s bus;
    tcasm_rx_s  rx;
    logic [7:0] rd_data, r;
    logic [7:0] exp_q[$];
    int         error_cnt, n_tests;
    // ============================================================
    // Clock and units; a short RAI period keeps the run brief.
    always #5 sys_clk = ~sys_clk;
    tcasm_monitor #(.RAI_PERIOD_CYC(200)) i_tcasm_monitor (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
        .rd_data(rd_data), .rx(rx), .rx_ci_alarm_signal_state(ais_s),
        .rx_ci_remote_alarm_state(rai_s), .irq(irq));
    tcasm_line_model i_tcasm_line_model (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .ais_on(ais_on), .rai_on(rai_on),
        .slow(slow), .rx(rx));
    // ============================================================
    // Tasks
    task wrap_up;
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One strobe per call; a read notes its expected data.
    task op(input logic w, input logic [3:0] a, input logic [7:0] d,
            input logic [7:0] e);
        @(posedge sys_clk);
        bus <= '{a, d, w, !w};
        if (!w) exp_q.push_back(e);
    endtask
    task nap(input int n);
        @(posedge sys_clk);
        bus <= '0;
        repeat (n) @(posedge sys_clk);
    endtask
    task waitst(input logic sel, input logic v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge sys_clk);
            bus <= '0;
            if ((sel ? rai_s : ais_s) === v) break;
        end
        if (i == n) begin
            error_cnt++;
            $display("[ERR] %0t state wait ran out", $time);
        end
    endtask
    // Interrupt level, read where the last edge has settled it.
    task irq_is(input logic v);
        n_tests++;
        if (irq !== v) begin
            error_cnt++;
            $display("[ERR] %0t irq %b", $time, irq);
        end
    endtask
    // ============================================================
    // Read data stands only in the cycle after the strobe.
    always @(posedge sys_clk) begin
        rd_q <= bus.rd;
        if (rd_q === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
                error_cnt++;
                $display("[ERR] %0t read %h", $time, rd_data);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    // ============================================================
    // Main sequence and watchdog
    initial begin
        #300000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hBAE3E792));
        sys_clk = 0; sys_rst = 1; bus = '0; rd_q = 0;
        ais_on = 0; rai_on = 0; slow = 1; error_cnt = 0; n_tests = 0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 0;
        op(0, 4'h0, 0, 8'h00);
        op(0, 4'h1, 0, 8'h00);
        op(0, 4'h2, 0, 8'h00);
        op(0, 4'hF, 0, 8'h00);
        r = 8'($urandom);
        op(1, 4'h0, r, 0);
        op(0, 4'h0, 0, 8'h00);
        op(1, 4'h2, r, 0);
        op(0, 4'h2, 0, r & 8'h03);
        op(1, 4'h2, 8'h02, 0);
        op(1, 4'hF, r, 0);
        op(0, 4'h1, 0, 8'h00);
        ais_on <= 1;
        nap(4500);
        op(0, 4'h0, 0, 8'h00);
        op(1, 4'h1, 8'h01, 0);
        waitst(0, 1, 1600);
        irq_is(1'b1);
        op(0, 4'h0, 0, 8'h22);
        op(0, 4'h0, 0, 8'h20);
        ais_on <= 0;
        waitst(0, 0, 1800);
        irq_is(1'b1);
        op(0, 4'h0, 0, 8'h02);
        slow <= 0;
        rai_on <= 1;
        op(1, 4'h1, 8'h02, 0);
        nap(800);
        op(0, 4'h0, 0, 8'h00);
        op(1, 4'h1, 8'h04, 0);
        nap(800);
        op(0, 4'h0, 0, 8'h00);
        op(1, 4'h2, 8'h01, 0);
        op(1, 4'h1, 8'h06, 0);
        waitst(1, 1, 800);
        irq_is(1'b1);
        op(0, 4'h0, 0, 8'h11);
        op(0, 4'h1, 0, 8'h06);
        rai_on <= 0;
        waitst(1, 0, 700);
        op(0, 4'h0, 0, 8'h01);
        rai_on <= 1;
        waitst(1, 1, 800);
        // A change under a cleared mask must leave the interrupt low.
        op(1, 4'h2, 8'h00, 0);
        op(1, 4'h1, 8'h02, 0);
        waitst(1, 0, 3);
        irq_is(1'b0);
        op(0, 4'h0, 0, 8'h01);
        nap(3);
        wrap_up;
    end
endmodule
bind tcasm_monitor tcasm_chk i_tcasm_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
    .rx_ci_alarm_signal_state(rx_ci_alarm_signal_state),
    .rx_ci_remote_alarm_state(rx_ci_remote_alarm_state), .irq(irq));
